// ==== hdl/horizontal_scaler.sv ====
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
// =====================================================
module horizontal_scaler
    import hscale_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hsync,
    input wire logic pixel_qualifier,
    input wire logic [7:0] in_luma,
    input wire logic [7:0] in_chroma,
    output logic out_valid,
    output logic [7:0] out_luma,
    output logic [7:0] out_chroma
);
    // =====================================================
    // register file
    logic [31:0] pre_r, pre_nxt, fine_r, fine_nxt, adj_r, adj_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pslverr_r, pslverr_nxt;
    logic access;

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == prescaler_ctrl_off) || (a == fine_scale_ctrl_off) || (a == picture_adjust_off);
    endfunction

    // zero-wait slave: answers in the first access cycle
    always_comb begin
        access = psel && penable;
        pre_nxt = pre_r;
        fine_nxt = fine_r;
        adj_nxt = adj_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        // read data is latched in setup so it stands through the whole access cycle
        if (psel && !penable) begin
            pslverr_nxt = !mapped(paddr);
            unique case (paddr)
                prescaler_ctrl_off: prdata_nxt = pre_r;
                fine_scale_ctrl_off: prdata_nxt = fine_r;
                picture_adjust_off: prdata_nxt = adj_r;
                default: prdata_nxt = 32'h00000000;
            endcase
        end
        // writes land only at the access edge; an unmapped address changes nothing
        if (access && pwrite) begin
            // masks keep reserved bits at zero
            if (paddr == prescaler_ctrl_off) pre_nxt = pwdata & prescaler_ctrl_mask;
            if (paddr == fine_scale_ctrl_off) fine_nxt = pwdata & fine_scale_ctrl_mask;
            if (paddr == picture_adjust_off) adj_nxt = pwdata & picture_adjust_mask;
        end
    end

    // register state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_r <= reg_reset;
            fine_r <= reg_reset;
            adj_r <= reg_reset;
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            fine_r <= fine_nxt;
            adj_r <= adj_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_r;
    // error only shows while the access phase stands, never in setup
    assign pslverr = pslverr_r && access;

    // =====================================================
    // fields
    // reserved bits are masked at write, so these slices never see them
    logic [2:0] dc_gain;
    logic [5:0] prescale_factor;
    logic accumulation_mode, interpolation_mode;
    logic [7:0] luma_tap_weights, chroma_tap_weights;
    logic [6:0] start_phase;
    logic [11:0] phase_increment, horizontal_start_offset;
    assign dc_gain = pre_r[dc_gain_lsb +: 3];
    assign prescale_factor = pre_r[prescale_factor_lsb +: 6];
    assign accumulation_mode = pre_r[accumulation_mode_bit];
    assign luma_tap_weights = pre_r[luma_tap_weights_lsb +: 8];
    assign chroma_tap_weights = pre_r[chroma_tap_weights_lsb +: 8];
    assign interpolation_mode = fine_r[interpolation_mode_bit];
    assign start_phase = fine_r[start_phase_lsb +: 7];
    assign phase_increment = fine_r[phase_increment_lsb +: 12];
    assign horizontal_start_offset = fine_r[horizontal_start_offset_lsb +: 12];

    // =====================================================
    // pin synchronisers, two flops each
    // reset to each pin's idle level, so no false sync edge follows reset
    // limitation: pixel bits cross one by one and must be steady around the qualifier
    logic [17:0] sync1_r, sync2_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 18'h00000;
            sync2_r <= 18'h00000;
        end else begin
            sync1_r <= {hsync, pixel_qualifier, in_luma, in_chroma};
            sync2_r <= sync1_r;
        end
    end
    logic hs_s, q_s;
    logic [7:0] y_s, c_s;
    assign {hs_s, q_s, y_s, c_s} = sync2_r;

    // =====================================================
    // horizontal start, prescaler and phase
    logic hs_d_r, hs_d_nxt;
    logic [11:0] skip_r, skip_nxt;
    logic [5:0] pos_r, pos_nxt;
    // accumulators are 17 bits: 64 pixels at double weight cannot overflow
    logic [16:0] accy_r, accy_nxt, accc_r, accc_nxt;
    logic [16:0] addy, addc, sumy, sumc;
    logic [2:0] tap;
    logic pre_v_r, pre_v_nxt;
    logic [7:0] pre_y_r, pre_y_nxt, pre_c_r, pre_c_nxt;
    logic [16:0] phase_r, phase_nxt;
    logic ph_v_r, ph_v_nxt;
    logic [7:0] ph_y_r, ph_y_nxt, ph_c_r, ph_c_nxt;
    logic take, last;
    logic line_start;

    // gain shift: 000..011 -> 0..3, 100..111 -> 1..4
    function automatic logic [16:0] apply_gain(input logic [16:0] v, input logic [2:0] g);
        logic [2:0] sh;
        sh = g[2] ? ({1'b0, g[1:0]} + 3'd1) : {1'b0, g[1:0]};
        apply_gain = v >> sh;
    endfunction

    // saturate rather than wrap, so an under-set gain clips to white
    function automatic logic [7:0] sat8(input logic [16:0] v);
        sat8 = (v > 17'd255) ? 8'hff : v[7:0];
    endfunction

    // tap weight: a set bit doubles the pixel, a clear bit passes it once
    function automatic logic [16:0] weigh(input logic [7:0] s, input logic w);
        weigh = w ? {8'h00, s, 1'b0} : {9'h000, s};
    endfunction

    // one-cycle pulse on the rising sync edge
    assign line_start = hs_s && !hs_d_r;

    // offset skip: rising sync edge restarts the count of qualified pixels
    always_comb begin
        hs_d_nxt = hs_s;
        skip_nxt = skip_r;
        if (line_start) begin
            skip_nxt = horizontal_start_offset;
        end else if (q_s && skip_r != 12'h000) begin
            skip_nxt = skip_r - 12'h001;
        end
        // the sync cycle itself never carries a pixel into the window
        take = q_s && skip_r == 12'h000 && !line_start;
    end

    // offset skip registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_d_r <= 1'b0;
            skip_r <= 12'h000;
        end else begin
            hs_d_r <= hs_d_nxt;
            skip_r <= skip_nxt;
        end
    end

    // prescaler: weighted accumulation, one sample out per window
    always_comb begin
        tap = pos_r[2:0]; // taps repeat every eight pixels and restart at each window
        addy = weigh(y_s, luma_tap_weights[tap]);
        addc = weigh(c_s, chroma_tap_weights[tap]);
        sumy = accy_r + addy;
        sumc = accc_r + addc;
        last = pos_r == prescale_factor;
        pos_nxt = pos_r;
        accy_nxt = accy_r;
        accc_nxt = accc_r;
        pre_v_nxt = 1'b0;
        pre_y_nxt = pre_y_r;
        pre_c_nxt = pre_c_r;
        // a window cut by a sync edge is dropped, not flushed
        if (line_start) begin
            pos_nxt = 6'h00;
            accy_nxt = 17'h00000;
            accc_nxt = 17'h00000;
        end else if (take) begin
            pos_nxt = last ? 6'h00 : pos_r + 6'h01;
            accy_nxt = sumy;
            accc_nxt = sumc;
            if (last) begin
                pre_v_nxt = 1'b1;
                pre_y_nxt = sat8(apply_gain(sumy, dc_gain));
                pre_c_nxt = sat8(apply_gain(sumc, dc_gain));
                // overlapping keeps the last sample as the next window seed
                accy_nxt = accumulation_mode ? 17'h00000 : addy;
                accc_nxt = accumulation_mode ? 17'h00000 : addc;
            end
        end
    end

    // prescaler registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_r <= 6'h00;
            accy_r <= 17'h00000;
            accc_r <= 17'h00000;
            pre_v_r <= 1'b0;
            pre_y_r <= 8'h00;
            pre_c_r <= 8'h00;
        end else begin
            pos_r <= pos_nxt;
            accy_r <= accy_nxt;
            accc_r <= accc_nxt;
            pre_v_r <= pre_v_nxt;
            pre_y_r <= pre_y_nxt;
            pre_c_r <= pre_c_nxt;
        end
    end

    // fine scaler: phase in 1/1024 pixel; start phase is in 1/128
    always_comb begin
        phase_nxt = phase_r;
        ph_v_nxt = 1'b0;
        ph_y_nxt = ph_y_r;
        ph_c_nxt = ph_c_r;
        if (line_start) begin
            phase_nxt = {7'h00, start_phase, 3'h0};
        end else if (pre_v_r) begin
            // fixed mode reloads the start phase, so every window yields a sample
            if (interpolation_mode) begin
                phase_nxt = {7'h00, start_phase, 3'h0};
            end else begin
                phase_nxt = phase_r + {5'h00, phase_increment};
            end
            // emit one sample each time the phase crosses a whole pixel
            ph_v_nxt = interpolation_mode || (phase_nxt[16:phase_frac_bits] != phase_r[16:phase_frac_bits]);
            ph_y_nxt = pre_y_r;
            ph_c_nxt = pre_c_r;
        end
    end

    // fine scaler registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= 17'h00000;
            ph_v_r <= 1'b0;
            ph_y_r <= 8'h00;
            ph_c_r <= 8'h00;
        end else begin
            phase_r <= phase_nxt;
            ph_v_r <= ph_v_nxt;
            ph_y_r <= ph_y_nxt;
            ph_c_r <= ph_c_nxt;
        end
    end

    // =====================================================
    // picture adjust stage
    // one more register stage; new settings apply to samples entering it
    picture_adjust u_adjust (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(ph_v_r),
        .in_luma(ph_y_r),
        .in_chroma(ph_c_r),
        .brightness(adj_r[brightness_lsb +: 8]),
        .contrast(adj_r[contrast_lsb +: 8]),
        .saturation(adj_r[saturation_lsb +: 8]),
        .out_valid(out_valid),
        .out_luma(out_luma),
        .out_chroma(out_chroma)
    );
endmodule

// ==== hdl/hscale_pkg.sv ====
package hscale_pkg;
    // =====================================================
    // register map
    localparam logic [7:0] prescaler_ctrl_off = 8'h68;
    localparam logic [7:0] fine_scale_ctrl_off = 8'h6c;
    localparam logic [7:0] picture_adjust_off = 8'h70;
    // =====================================================
    // field layout, prescaler control
    localparam int dc_gain_lsb = 27;
    localparam int prescale_factor_lsb = 18;
    localparam int accumulation_mode_bit = 17;
    localparam int luma_tap_weights_lsb = 8;
    localparam int chroma_tap_weights_lsb = 0;
    // =====================================================
    // field layout, fine scale control
    localparam int interpolation_mode_bit = 31;
    localparam int start_phase_lsb = 24;
    localparam int phase_increment_lsb = 12;
    localparam int horizontal_start_offset_lsb = 0;
    // =====================================================
    // field layout, picture adjust
    localparam int brightness_lsb = 24;
    localparam int contrast_lsb = 16;
    localparam int saturation_lsb = 0;
    // =====================================================
    // writable masks and reset values
    localparam logic [31:0] prescaler_ctrl_mask = 32'h38feffff;
    localparam logic [31:0] fine_scale_ctrl_mask = 32'hffffffff;
    localparam logic [31:0] picture_adjust_mask = 32'hffff00ff;
    localparam logic [31:0] reg_reset = 32'h00000000;
    // =====================================================
    // video constants
    localparam logic [7:0] nominal_brightness = 8'h80;
    localparam logic [7:0] unity_gain = 8'h40;
    localparam logic [7:0] chroma_zero = 8'h80;
    localparam int phase_frac_bits = 10;
endpackage

// ==== hdl/picture_adjust.sv ====
`timescale 1ns/1ps
// =====================================================
// brightness, contrast and saturation on one sample
module picture_adjust
    import hscale_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    input wire logic [7:0] in_luma,
    input wire logic [7:0] in_chroma,
    input wire logic [7:0] brightness,
    input wire logic [7:0] contrast,
    input wire logic [7:0] saturation,
    output logic out_valid,
    output logic [7:0] out_luma,
    output logic [7:0] out_chroma
);
    logic out_valid_r, out_valid_nxt;
    logic [7:0] luma_r, luma_nxt, chroma_r, chroma_nxt;
    logic signed [17:0] y_prod;
    logic signed [17:0] c_prod;
    logic signed [17:0] y_sum;
    logic signed [17:0] c_sum;

    // clamp a signed intermediate to 0..255
    function automatic logic [7:0] clamp8(input logic signed [17:0] v);
        if (v < 0) begin
            clamp8 = 8'h00;
        end else if (v > 18'sd255) begin
            clamp8 = 8'hff;
        end else begin
            clamp8 = v[7:0];
        end
    endfunction

    // gain 0x40 is unity, so the product is scaled down by 64
    always_comb begin
        y_prod = $signed({10'h000, in_luma}) * $signed({10'h000, contrast});
        y_sum = (y_prod >>> 6) + $signed({10'h000, brightness}) - $signed({10'h000, nominal_brightness});
        c_prod = ($signed({10'h000, in_chroma}) - $signed({10'h000, chroma_zero}))
            * $signed({10'h000, saturation});
        c_sum = (c_prod >>> 6) + $signed({10'h000, chroma_zero});
        out_valid_nxt = in_valid;
        luma_nxt = in_valid ? clamp8(y_sum) : luma_r;
        chroma_nxt = in_valid ? clamp8(c_sum) : chroma_r;
    end

    // output registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid_r <= 1'b0;
            luma_r <= 8'h00;
            chroma_r <= 8'h00;
        end else begin
            out_valid_r <= out_valid_nxt;
            luma_r <= luma_nxt;
            chroma_r <= chroma_nxt;
        end
    end

    assign out_valid = out_valid_r;
    assign out_luma = luma_r;
    assign out_chroma = chroma_r;
endmodule

// ==== verification/hscale_asserts.sv ====
`timescale 1ns/1ps
// =====================================================
// port checks for the horizontal scaler
module hscale_checks
    import hscale_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hsync,
    input wire logic pixel_qualifier,
    input wire logic [7:0] in_luma,
    input wire logic [7:0] in_chroma,
    input wire logic out_valid,
    input wire logic [7:0] out_luma,
    input wire logic [7:0] out_chroma
);
    logic [31:0] adj_r;
    logic [31:0] adj_nxt;
    logic [3:0] idle_r;
    logic [3:0] idle_nxt;
    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr == prescaler_ctrl_off || paddr == fine_scale_ctrl_off || paddr == picture_adjust_off;
    // shadow of picture adjust; idle count saturates so it never wraps to look busy
    always_comb begin
        adj_nxt = adj_r;
        idle_nxt = pixel_qualifier ? 4'h0 : (idle_r == 4'hf ? idle_r : idle_r + 4'h1);
        if (acc && pwrite && paddr == picture_adjust_off) begin
            adj_nxt = pwdata & picture_adjust_mask;
        end
    end
    // helper registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adj_r <= 32'h00000000;
            idle_r <= 4'h0;
        end else begin
            adj_r <= adj_nxt;
            idle_r <= idle_nxt;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =====================================================
    // assertions
    chk_reset_quiet: assert property ($rose(presetn) |-> !out_valid && prdata == 32'h00000000)
        else $error("outputs not clear after reset");
    chk_unmapped_err: assert property (acc && !mapped |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped access refused");
    chk_resv_zero: assert property (acc && !pwrite && paddr == prescaler_ctrl_off |->
        (prdata & ~prescaler_ctrl_mask) == 32'h00000000)
        else $error("reserved bits not zero");
    chk_adjust_readback: assert property (acc && !pwrite && paddr == picture_adjust_off |-> prdata == adj_r)
        else $error("picture adjust readback wrong");
    chk_quiet_idle: assert property (out_valid |-> idle_r < 4'hc)
        else $error("output without recent input");
    chk_luma_off: assert property (out_valid && adj_r[23:16] == 8'h00 && adj_r[31:24] == nominal_brightness
        |-> out_luma == 8'h00)
        else $error("luma not off at zero contrast");
    chk_colour_off: assert property (out_valid && adj_r[7:0] == 8'h00 |-> out_chroma == chroma_zero)
        else $error("colour not off at zero saturation");
endmodule
bind horizontal_scaler hscale_checks u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync(hsync), .pixel_qualifier(pixel_qualifier), .in_luma(in_luma), .in_chroma(in_chroma),
    .out_valid(out_valid), .out_luma(out_luma), .out_chroma(out_chroma));

// ==== verification/video_source.sv ====
`timescale 1ns/1ps
// =====================================================
// upstream video input path: one line of flat pixels
module video_source (
    input wire logic pclk,
    input wire logic go,
    input wire logic gap,
    input wire logic [7:0] npix,
    input wire logic [7:0] y,
    input wire logic [7:0] c,
    output logic hsync = 1'b0,
    output logic pixel_qualifier = 1'b0,
    output logic [7:0] in_luma = 8'h00,
    output logic [7:0] in_chroma = 8'h00,
    output logic busy = 1'b0
);
    logic [7:0] left = 8'h00;
    logic tog = 1'b0;
    logic q;
    // sync edge first, then qualified pixels; unqualified data toggles so stale values never match
    always @(posedge pclk) begin
        q = busy && left != 8'h00 && !(gap && tog);
        hsync <= go && !busy;
        pixel_qualifier <= q;
        in_luma <= q ? y : ~in_luma;
        in_chroma <= q ? c : ~in_chroma;
        tog <= ~tog;
        if (go && !busy) begin
            left <= npix;
            busy <= 1'b1;
        end else if (busy) begin
            left <= q ? left - 8'h01 : left;
            busy <= left != 8'h00;
        end
    end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
// =====================================================
// bench top
module tb_top;
    import hscale_pkg::*;
    typedef struct packed {logic [31:0] pre, fin, adj; logic [7:0] n; logic g; logic [7:0] y, c, k, ey, ec;} row_s;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0, gap = 1'b0;
    logic [7:0] paddr = 8'h00, npix = 8'h00, y = 8'h00, c = 8'h00, ly, lc, out_luma, out_chroma, in_luma, in_chroma;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, er, hsync, pq, out_valid, busy;
    int mismatches = 0, checked = 0, nout = 0;
    row_s rows [0:12] = '{
        '{32'h00020000,32'h80000000,32'h80400040,8'h04,1'b0,8'h55,8'h33,8'h04,8'h55,8'h33},
        '{32'h00020000,32'h80000000,32'h80000040,8'h04,1'b0,8'h55,8'h33,8'h04,8'h00,8'h33},
        '{32'h00020000,32'h80000000,32'h807f0040,8'h04,1'b0,8'h40,8'h33,8'h04,8'h7f,8'h33},
        '{32'h00020000,32'h80000000,32'hff400040,8'h04,1'b0,8'h10,8'h33,8'h04,8'h8f,8'h33},
        '{32'h00020000,32'h80000000,32'h80400000,8'h04,1'b0,8'h55,8'h33,8'h04,8'h55,8'h80},
        '{32'h00020000,32'h80000000,32'h8040007f,8'h04,1'b0,8'h55,8'hc0,8'h04,8'h55,8'hff},
        '{32'h08060000,32'h80000000,32'h80400040,8'h08,1'b0,8'h55,8'h33,8'h04,8'h55,8'h33},
        '{32'h10060303,32'h80000000,32'h80400040,8'h08,1'b0,8'h55,8'h33,8'h04,8'h55,8'h33},
        '{32'h381effff,32'h80000000,32'h80400040,8'h10,1'b0,8'h55,8'h33,8'h02,8'h55,8'h33},
        '{32'h00020000,32'h00200000,32'h80400040,8'h08,1'b0,8'h55,8'h33,8'h04,8'h55,8'h33},
        '{32'h00020000,32'h80000003,32'h80400040,8'h07,1'b1,8'h55,8'h33,8'h04,8'h55,8'h33},
        '{32'h08040000,32'h80000000,32'h80400040,8'h08,1'b0,8'h40,8'h20,8'h04,8'h60,8'h30},
        '{32'h00020000,32'h40200000,32'h80400040,8'h01,1'b0,8'h55,8'h33,8'h01,8'h55,8'h33}};
    horizontal_scaler DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hsync(hsync),
        .pixel_qualifier(pq), .in_luma(in_luma), .in_chroma(in_chroma), .out_valid(out_valid),
        .out_luma(out_luma), .out_chroma(out_chroma));
    video_source src (.pclk(pclk), .go(go), .gap(gap), .npix(npix), .y(y), .c(c), .hsync(hsync),
        .pixel_qualifier(pq), .in_luma(in_luma), .in_chroma(in_chroma), .busy(busy));
    // clock
    initial begin
        forever #12.5 pclk = ~pclk;
    end
    // output counter, last sample kept for the compare
    always @(posedge pclk) begin
        if (out_valid === 1'b1) begin
            nout <= nout + 1;
            ly <= out_luma;
            lc <= out_chroma;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // apb master: hold the request until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task end_sim;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // watchdog, far beyond the roughly 500 cycles the tests need
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_sim();
    end
    // =====================================================
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, prescaler_ctrl_off, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, fine_scale_ctrl_off, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, picture_adjust_off, 32'h0);
        chk(rd, 32'h0);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, prescaler_ctrl_off, rows[i].pre);
            apb(1'b1, fine_scale_ctrl_off, rows[i].fin);
            apb(1'b1, picture_adjust_off, rows[i].adj);
            {npix, gap, y, c} <= {rows[i].n, rows[i].g, rows[i].y, rows[i].c};
            go <= 1'b1;
            nout = 0;
            @(posedge pclk);
            go <= 1'b0;
            @(posedge pclk);
            while (busy === 1'b1) @(posedge pclk);
            repeat (16) @(posedge pclk);
            chk(32'(nout), {24'h0, rows[i].k});
            chk({24'h0, ly}, {24'h0, rows[i].ey});
            chk({24'h0, lc}, {24'h0, rows[i].ec});
            $display("row %0d done", i);
        end
        apb(1'b1, prescaler_ctrl_off, 32'hffffffff);
        apb(1'b0, prescaler_ctrl_off, 32'h0);
        chk(rd, prescaler_ctrl_mask);
        apb(1'b1, picture_adjust_off, 32'hffffffff);
        apb(1'b0, picture_adjust_off, 32'h0);
        chk(rd, picture_adjust_mask);
        apb(1'b1, 8'h74, 32'hffffffff);
        apb(1'b0, 8'h74, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        $display("register test done");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, picture_adjust_off, 32'h0);
        chk(rd, 32'h0);
        $display("reset test done");
        end_sim();
    end
endmodule
